// file: design/node_report_dma.sv
// Capture DMA that stores node identification packets after a bus reset.
`timescale 1ns/1ns
module node_report_dma (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_reset,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [31:0] o_reg_rdata,
    // Link receive path.
    input wire logic i_bus_reset,
    input wire logic i_phase_end,
    input wire logic i_rx_valid,
    input wire logic [31:0] i_rx_data,
    input wire logic i_rx_error,
    input wire logic [31:0] i_cycle_time,
    // Packets outside the identification phase.
    output logic o_other_valid,
    output logic [31:0] o_other_data,
    // Host memory write port.
    output logic o_mem_valid,
    output node_report_pkg::mem_write_t o_mem_req,
    input wire logic i_mem_ready,
    input wire logic i_mem_error,
    // Events.
    output logic o_bus_reset_event,
    output logic o_done_event
);
    ////////////////////////////////////////////////////////////////////////////
    // State.
    logic [20:0] base_r;
    logic accept_r;
    logic [7:0] epoch_r;
    logic [8:0] size_r;
    logic fault_r;
    logic err_seen_r;
    logic phase_r;
    logic [8:0] waddr_r;
    node_report_pkg::capture_state_t state_r;
    node_report_pkg::capture_state_t state_nxt;
    logic [31:0] rdata_r;
    logic mem_valid_r;
    node_report_pkg::mem_write_t mem_req_r;
    logic other_valid_r;
    logic [31:0] other_data_r;
    logic bus_reset_ev_r;
    logic done_ev_r;
    logic phase_end_seen_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    wire wr_ptr = i_reg_write && hit(i_reg_addr, node_report_pkg::OFS_BUFFER_POINTER);
    wire wr_ctl = i_reg_write && hit(i_reg_addr, node_report_pkg::OFS_CONTROL);
    wire [31:0] count_word = {fault_r, 7'h00, epoch_r, 5'h00, size_r, 2'h0};
    wire [31:0] ptr_word = {base_r, 11'h000};
    wire [31:0] ctl_word = {31'h00000000, accept_r};
    wire [31:0] rd_sel =
        hit(i_reg_addr, node_report_pkg::OFS_BUFFER_POINTER) ? ptr_word :
        hit(i_reg_addr, node_report_pkg::OFS_COUNT) ? count_word :
        hit(i_reg_addr, node_report_pkg::OFS_CONTROL) ? ctl_word : 32'h00000000;

    always_ff @(posedge i_clock)
    begin
        rdata_r <= i_reg_read ? rd_sel : 32'h00000000;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            base_r <= node_report_pkg::BASE_RESET;
        else if (wr_ptr)
            base_r <= i_reg_wdata[31:node_report_pkg::BASE_LSB];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            accept_r <= 1'b0;
        else if (wr_ctl)
            accept_r <= i_reg_wdata[node_report_pkg::CONTROL_ACCEPT_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data FIFO between link and memory writer.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;
    logic fifo_pop;
    wire capture_in = i_rx_valid && phase_r && accept_r && !err_seen_r;
    // Data while the FIFO is full is an overrun, which counts as a receive error.
    wire overrun = capture_in && !fifo_in_ready;

    node_report_fifo #(
        .WIDTH(32),
        .DEPTH(4)
    ) u_fifo (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_in_valid(capture_in),
        .i_in_data(i_rx_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(fifo_pop),
        .i_flush(i_bus_reset || err_seen_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Capture sequencing.
    wire mem_done = mem_valid_r && i_mem_ready;
    wire mem_idle = !mem_valid_r || i_mem_ready;
    wire at_full = (waddr_r == node_report_pkg::SIZE_FULL);
    // A full buffer is declared only after the last write has landed, so size cannot wrap.
    wire overflow = (state_r == node_report_pkg::ST_DATA) && at_full && fifo_out_valid
        && !mem_valid_r;
    wire err_now = i_rx_error || overrun || (mem_valid_r && i_mem_error);
    assign fifo_pop = (state_r == node_report_pkg::ST_DATA) && mem_idle && !err_seen_r
        && fifo_out_valid && !at_full;
    wire finish = (state_r == node_report_pkg::ST_DATA) && phase_end_seen_r && !fifo_out_valid
        && !mem_valid_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            node_report_pkg::ST_IDLE: state_nxt = node_report_pkg::ST_IDLE;
            node_report_pkg::ST_HEADER:
                if (mem_idle)
                    state_nxt = node_report_pkg::ST_DATA;
            node_report_pkg::ST_DATA:
                if (finish)
                    state_nxt = node_report_pkg::ST_IDLE;
            node_report_pkg::ST_DRAIN: state_nxt = node_report_pkg::ST_IDLE;
            default: state_nxt = node_report_pkg::ST_IDLE;
        endcase
        if (i_bus_reset)
            state_nxt = node_report_pkg::ST_HEADER;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            state_r <= node_report_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            phase_r <= 1'b0;
        else if (i_bus_reset)
            phase_r <= 1'b1;
        else if (i_phase_end)
            phase_r <= 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset || i_bus_reset)
            phase_end_seen_r <= 1'b0;
        else if (i_phase_end && phase_r)
            phase_end_seen_r <= 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            epoch_r <= node_report_pkg::EPOCH_RESET;
        else if (i_bus_reset)
            epoch_r <= epoch_r + 8'h01;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset || i_bus_reset)
            size_r <= node_report_pkg::SIZE_RESET;
        else if (overflow)
            size_r <= node_report_pkg::SIZE_OVERFLOW[8:0];
        else if (mem_done && !i_mem_error)
            size_r <= size_r + 9'h001;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset || i_bus_reset)
            err_seen_r <= 1'b0;
        else if (err_now || overflow)
            err_seen_r <= 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            fault_r <= 1'b0;
        else if (err_now || err_seen_r)
            fault_r <= 1'b1;
        else if (finish)
            fault_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory writer.
    wire [31:0] header_word = {8'h00, epoch_r, i_cycle_time[27:25], i_cycle_time[24:12]};
    wire hdr_go = (state_r == node_report_pkg::ST_HEADER) && mem_idle;

    always_ff @(posedge i_clock)
    begin
        if (i_reset || i_bus_reset)
            waddr_r <= 9'h000;
        else if (hdr_go || fifo_pop)
            waddr_r <= waddr_r + 9'h001;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset || i_bus_reset)
            mem_valid_r <= 1'b0;
        else if (hdr_go || fifo_pop)
            mem_valid_r <= 1'b1;
        else if (i_mem_ready)
            mem_valid_r <= 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            mem_req_r <= '0;
        else if (hdr_go)
            mem_req_r <= '{addr: {base_r, 11'h000}, data: header_word};
        else if (fifo_pop)
            mem_req_r <= '{addr: {base_r, waddr_r, 2'h0}, data: fifo_out_data};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events and the path for packets outside the phase.
    // route outside phase
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            other_valid_r <= 1'b0;
            other_data_r <= 32'h00000000;
        end
        else
        begin
            other_valid_r <= i_rx_valid && !phase_r && accept_r;
            other_data_r <= i_rx_data;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            done_ev_r <= 1'b0;
            bus_reset_ev_r <= 1'b0;
        end
        else
        begin
            done_ev_r <= finish;
            bus_reset_ev_r <= i_bus_reset;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_mem_valid = mem_valid_r;
    assign o_mem_req = mem_req_r;
    assign o_other_valid = other_valid_r;
    assign o_other_data = other_data_r;
    assign o_bus_reset_event = bus_reset_ev_r;
    assign o_done_event = done_ev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence bus_reset_seen;
        i_bus_reset;
    endsequence

    AST_EPOCH_STEP: assert property (@(posedge i_clock) disable iff (i_reset)
        i_bus_reset |=> epoch_r == $past(epoch_r) + 8'h01)
        else $error("epoch did not advance on bus reset");

    AST_SIZE_ZERO: assert property (@(posedge i_clock) disable iff (i_reset)
        bus_reset_seen |=> size_r == 9'h000 && bus_reset_ev_r)
        else $error("size not zeroed with reset event");

    AST_HEADER_FIRST: assert property (@(posedge i_clock) disable iff (i_reset)
        hdr_go && !i_bus_reset |=> mem_valid_r && mem_req_r.data[23:16] == epoch_r
            && mem_req_r.addr[10:0] == 11'h000)
        else $error("header not first with epoch");

    AST_ALIGNED: assert property (@(posedge i_clock) disable iff (i_reset)
        mem_valid_r |-> mem_req_r.addr[31:11] == base_r)
        else $error("write outside buffer");

    AST_SIZE_STEP: assert property (@(posedge i_clock) disable iff (i_reset)
        mem_done && !i_mem_error && !i_bus_reset && !(at_full && fifo_out_valid)
        |=> size_r == $past(size_r) + 9'h001)
        else $error("size not advanced on write");

    AST_DISCARD: assert property (@(posedge i_clock) disable iff (i_reset)
        err_seen_r && state_r == node_report_pkg::ST_DATA && !i_bus_reset
        |=> $stable(mem_req_r))
        else $error("data written after error");

    AST_FAULT_SET: assert property (@(posedge i_clock) disable iff (i_reset)
        i_rx_error && !i_bus_reset |=> fault_r)
        else $error("fault not set on error");

    AST_RESTART: assert property (@(posedge i_clock) disable iff (i_reset)
        i_bus_reset |=> state_r == node_report_pkg::ST_HEADER && waddr_r == 9'h000)
        else $error("capture not restarted");

    AST_ACCEPT: assert property (@(posedge i_clock) disable iff (i_reset)
        !accept_r |=> !other_valid_r)
        else $error("packet accepted while disabled");

endmodule : node_report_dma

// file: design/node_report_pkg.sv
// Package with register map, field layout and shared types of the node report capture DMA.
package node_report_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] OFS_BUFFER_POINTER = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;

    // Field positions.
    localparam int BASE_LSB = 11;
    localparam int CONTROL_ACCEPT_BIT = 0;
    localparam int COUNT_FAULT_BIT = 31;
    localparam int COUNT_EPOCH_LSB = 16;
    localparam int COUNT_SIZE_LSB = 2;
    localparam int HDR_EPOCH_LSB = 16;

    // Reset values of the control state.
    localparam logic [7:0] EPOCH_RESET = 8'h00;
    localparam logic [8:0] SIZE_RESET = 9'h000;
    localparam logic [20:0] BASE_RESET = 21'h000000;

    // Capture limits: 2048 bytes is 512 quadlets; the full-buffer size code.
    localparam int BUFFER_QUADLETS = 512;
    localparam logic [8:0] SIZE_FULL = 9'h1FF;
    // Only the low nine bits of the overflow code fit the size field.
    localparam logic [10:0] SIZE_OVERFLOW = 11'h7FF;
    localparam logic [7:0] EPOCH_MAX = 8'hFF;

    // Host write request toward memory.
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } mem_write_t;

    // Captured quadlet from the link receive path.
    typedef struct packed {
        logic [31:0] data;
    } link_quadlet_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HEADER = 2'b01,
        ST_DATA = 2'b10,
        ST_DRAIN = 2'b11
    } capture_state_t;

endpackage : node_report_pkg

// file: design/node_report_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module node_report_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_reset,
    // Filling side.
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Draining side.
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    input wire logic i_flush
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    wire full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
    wire empty = (wr_r == rd_r);
    wire push = i_in_valid && !full;
    wire pop = i_out_ready && !empty;

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_r[rd_r[AW-1:0]];

    always_ff @(posedge i_clock)
    begin
        if (push)
            mem_r[wr_r[AW-1:0]] <= i_in_data;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset || i_flush)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            wr_r <= wr_r + (AW+1)'(push);
            rd_r <= rd_r + (AW+1)'(pop);
        end
    end

endmodule : node_report_fifo

// file: dv/host_memory_model.sv
// Host memory model that takes quadlet writes, with stalls and one failing write on demand.
`timescale 1ns/1ns
module host_memory_model (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_reset,
    // Stall and fault control.
    input wire logic i_hold,
    input wire logic i_slow,
    input wire logic [31:0] i_fail_at,
    // Write port.
    input wire logic i_mem_valid,
    input wire node_report_pkg::mem_write_t i_mem_req,
    output logic o_mem_ready,
    output logic o_mem_error
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] writes_r;

    ////////////////////////////////////////////////////////////////////////////
    // A slow memory answers on alternate cycles, so held requests are exercised.
    always @(posedge i_clock)
    begin
        if (i_reset)
        begin
            o_mem_ready <= 1'b0;
            writes_r <= 32'h0;
        end
        else
        begin
            o_mem_ready <= i_hold ? 1'b0 : (i_slow ? ~o_mem_ready : 1'b1);
            if (i_mem_valid && o_mem_ready)
            begin
                writes_r <= writes_r + 32'h1;
                if (!o_mem_error)
                    mem[i_mem_req.addr] = i_mem_req.data;
            end
        end
    end

    assign o_mem_error = o_mem_ready && (writes_r == i_fail_at);
endmodule : host_memory_model

// file: dv/test_node_report_dma.sv
// Self-checking testbench of the node report capture DMA.
`timescale 1ns/1ns
module test_node_report_dma;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_reg_write = 1'b0;
    logic i_reg_read = 1'b0;
    logic [31:0] o_reg_rdata;
    logic i_bus_reset = 1'b0;
    logic i_phase_end = 1'b0;
    logic i_rx_valid = 1'b0;
    logic [31:0] i_rx_data = 32'h0;
    logic i_rx_error = 1'b0;
    logic [31:0] i_cycle_time = 32'h8ACF_1234;
    logic o_other_valid;
    logic [31:0] o_other_data;
    logic o_mem_valid;
    node_report_pkg::mem_write_t o_mem_req;
    logic i_mem_ready;
    logic i_mem_error;
    logic o_bus_reset_event;
    logic o_done_event;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic [31:0] fail_at = 32'hFFFF_FFFF;
    logic [31:0] rd;
    logic [7:0] ep = 8'h00;
    logic [31:0] base = 32'h1234_5800;
    int failures = 0;
    int checks = 0;

    always #50 i_clock = ~i_clock;

    node_report_dma node_report_dma_i (.i_clock(i_clock), .i_reset(i_reset),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
        .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .i_bus_reset(i_bus_reset),
        .i_phase_end(i_phase_end), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
        .i_rx_error(i_rx_error), .i_cycle_time(i_cycle_time), .o_other_valid(o_other_valid),
        .o_other_data(o_other_data), .o_mem_valid(o_mem_valid), .o_mem_req(o_mem_req),
        .i_mem_ready(i_mem_ready), .i_mem_error(i_mem_error),
        .o_bus_reset_event(o_bus_reset_event), .o_done_event(o_done_event));

    host_memory_model host_memory_model_i (.i_clock(i_clock), .i_reset(i_reset),
        .i_hold(hold), .i_slow(slow), .i_fail_at(fail_at), .i_mem_valid(o_mem_valid),
        .i_mem_req(o_mem_req), .o_mem_ready(i_mem_ready), .o_mem_error(i_mem_error));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    function automatic logic [31:0] count_word(input logic fault, input logic [8:0] size);
        return {fault, 7'h00, ep, 5'h00, size, 2'b00};
    endfunction : count_word

    ////////////////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge i_clock);
        i_reg_addr <= addr;
        i_reg_wdata <= data;
        i_reg_write <= 1'b1;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge i_clock);
        i_reg_addr <= addr;
        i_reg_read <= 1'b1;
        @(posedge i_clock);
        i_reg_read <= 1'b0;
        #1;
        data = o_reg_rdata;
    endtask : reg_read

    task automatic rx_word(input logic [31:0] data, input logic err);
        @(posedge i_clock);
        i_rx_valid <= ~err;
        i_rx_error <= err;
        i_rx_data <= data;
        @(posedge i_clock);
        i_rx_valid <= 1'b0;
        i_rx_error <= 1'b0;
    endtask : rx_word

    // Bus reset pulse; the epoch the design should now hold is tracked here.
    task automatic bus_reset();
        @(posedge i_clock);
        i_bus_reset <= 1'b1;
        @(posedge i_clock);
        i_bus_reset <= 1'b0;
        ep = ep + 8'h01;
        #1;
        check_bit(o_bus_reset_event, 1'b1);
        repeat (2) @(posedge i_clock);
    endtask : bus_reset

    task automatic finish_capture();
        @(posedge i_clock);
        i_phase_end <= 1'b1;
        @(posedge i_clock);
        i_phase_end <= 1'b0;
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge i_clock);
            #1;
            if (o_done_event === 1'b1)
                return;
        end
        failures++;
        report_and_stop();
    endtask : finish_capture

    task automatic check_count(input logic fault, input logic [8:0] size);
        reg_read(node_report_pkg::OFS_COUNT, rd);
        check_word(rd, count_word(fault, size));
    endtask : check_count

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge i_clock);
        i_reset <= 1'b0;
        check_count(1'b0, 9'h000);
        reg_write(node_report_pkg::OFS_BUFFER_POINTER, 32'h1234_5FFF);
        reg_read(node_report_pkg::OFS_BUFFER_POINTER, rd);
        check_word(rd, base);
        reg_write(node_report_pkg::OFS_COUNT, 32'hFFFF_FFFF);
        check_count(1'b0, 9'h000);
        reg_read(8'h0C, rd);
        check_word(rd, 32'h0);
        // Pointer first, then accept enable, as software must.
        reg_write(node_report_pkg::OFS_CONTROL, 32'h1);
        slow <= 1'b1;
        bus_reset();
        // Word 1 is not the inverse of word 0 and still lands in memory.
        for (int k = 0; k < 4; k++)
            rx_word(32'hC0DE_0000 + k, 1'b0);
        finish_capture();
        check_word(host_memory_model_i.mem[base], {8'h00, ep, 3'h5, 13'h0CF1});
        for (int k = 0; k < 4; k++)
            check_word(host_memory_model_i.mem[base + 4 * (k + 1)], 32'hC0DE_0000 + k);
        check_count(1'b0, 9'h005);
        check_word({24'h0, host_memory_model_i.mem[base][23:16]}, {24'h0, ep});
        hold <= 1'b1;
        bus_reset();
        check_count(1'b0, 9'h000);
        hold <= 1'b0;
        slow <= 1'b0;
        rx_word(32'hAB00_0001, 1'b0);
        rx_word(32'hAB00_0002, 1'b0);
        rx_word(32'h0, 1'b1);
        rx_word(32'hAB00_0003, 1'b0);
        finish_capture();
        check_count(1'b1, 9'h003);
        check_word(host_memory_model_i.mem[base + 12], 32'hC0DE_0002);
        bus_reset();
        fail_at <= host_memory_model_i.writes_r + 32'h1;
        rx_word(32'h5500_0001, 1'b0);
        rx_word(32'h5500_0002, 1'b0);
        finish_capture();
        reg_read(node_report_pkg::OFS_COUNT, rd);
        check_bit(rd[31], 1'b1);
        fail_at <= 32'hFFFF_FFFF;
        bus_reset();
        rx_word(32'h7700_0001, 1'b0);
        rx_word(32'h7700_0002, 1'b0);
        bus_reset();
        rx_word(32'h9900_0001, 1'b0);
        finish_capture();
        check_count(1'b0, 9'h002);
        check_word(host_memory_model_i.mem[base + 4], 32'h9900_0001);
        rx_word(32'h3300_00EE, 1'b0);
        #1;
        check_bit(o_other_valid, 1'b1);
        check_word(o_other_data, 32'h3300_00EE);
        reg_write(node_report_pkg::OFS_CONTROL, 32'h0);
        rx_word(32'h3300_00EF, 1'b0);
        #1;
        check_bit(o_other_valid, 1'b0);
        reg_write(node_report_pkg::OFS_CONTROL, 32'h1);
        while (ep != 8'h00)
        begin
            bus_reset();
            finish_capture();
        end
        check_count(1'b0, 9'h001);
        bus_reset();
        for (int k = 0; k < 520; k++)
            rx_word(k, 1'b0);
        finish_capture();
        check_count(1'b1, node_report_pkg::SIZE_FULL);
        report_and_stop();
    end
endmodule : test_node_report_dma
